/* csf_defs.svh */
// Constants for the core status flags and banked data memory layout
//
// Contract
// (RQ1) Status bits seven to five read zero
// (RQ2) Timeout flag sets on power-up, watchdog clear, sleep
// (RQ3) Timeout flag clears when watchdog expires
// (RQ4) Power-down flag sets on power-up, watchdog clear
// (RQ5) Power-down flag clears on sleep
// (RQ6) Zero flag follows all-zero result
// (RQ7) Nibble carry is carry out of bit three
// (RQ8) Carry is carry out of bit seven
// (RQ9) Borrow shows as inverted carry polarity
// (RQ10) Subtract adds two's complement of second operand
// (RQ11) Rotates load carry with shifted-out bit
// (RQ12) Flag access and reset values per reset kind
// (RQ13) Peripheral registers at bank offsets 0x0c-0x1f
// (RQ14) Up to 80 general RAM bytes per bank
// (RQ15) Sixteen common bytes same in every bank
// (RQ16) Linear pointer reaches general RAM without banking
// (RQ17) Thirty-two banks, numbered zero to thirty-one
// (RQ18) Status write of flags suppressed when instruction sets them
// (RQ19) Twelve-bit address: five bank, seven offset
// (RQ20) First twelve offsets are shared core registers
`ifndef CSF_DEFS_SVH
`define CSF_DEFS_SVH
`define CSF_BIT_TO        4
`define CSF_BIT_PD        3
`define CSF_BIT_Z         2
`define CSF_BIT_DC        1
`define CSF_BIT_C         0
`define CSF_OFF_STATUS    7'h03
`define CSF_OFF_BSR       7'h08
`define CSF_PERIPH_FIRST  7'h0c
`define CSF_GPR_FIRST     7'h20
`define CSF_COMMON_FIRST  7'h70
`define CSF_GPR_BYTES     12'h050
`define CSF_NUM_BANKS     32
`define CSF_LINEAR_SIZE   12'ha00
`endif

/* csf_pkg.sv */
// Types for the core status flags and banked data memory layout
package csf_pkg;
   typedef enum logic [2:0] {
      CSF_OP_ADD  = 3'h0,
      CSF_OP_SUB  = 3'h1,
      CSF_OP_AND  = 3'h2,
      CSF_OP_IOR  = 3'h3,
      CSF_OP_XOR  = 3'h4,
      CSF_OP_RL   = 3'h5,
      CSF_OP_RR   = 3'h6,
      CSF_OP_PASS = 3'h7
   } csf_alu_op_t;
   typedef enum logic [3:0] {
      CSF_RG_NONE   = 4'h0,
      CSF_RG_CORE   = 4'h1,
      CSF_RG_PERIPH = 4'h2,
      CSF_RG_GPR    = 4'h4,
      CSF_RG_COMMON = 4'h8
   } csf_region_t;
   typedef struct packed {
      logic [2:0] unused;
      logic       to;
      logic       pd;
      logic       z;
      logic       dc;
      logic       c;
   } csf_status_t;
   typedef struct packed {
      logic        valid;
      csf_alu_op_t op;
      logic [7:0]  a;
      logic [7:0]  b;
   } csf_alu_req_t;
   typedef struct packed {
      logic        valid;
      logic        write;
      logic        linear;
      logic [11:0] addr;
      logic [7:0]  wdata;
   } csf_acc_t;
endpackage : csf_pkg

/* csf_core.sv */
// Status flags, flag-setting ALU and banked data memory decoder
`timescale 1ns/1ps
`include "csf_defs.svh"
module csf_core (
   input  wire logic                 I_CLK_SYS,
   input  wire logic                 I_RST_N,
   input  wire logic                 I_OTHER_RST,
   input  wire logic                 I_WDT_CLEAR,
   input  wire logic                 I_SLEEP,
   input  wire logic                 I_WDT_EXPIRE,
   input  wire csf_pkg::csf_alu_req_t I_ALU,
   input  wire csf_pkg::csf_acc_t     I_ACC,
   output csf_pkg::csf_status_t      O_STATUS,
   output logic [7:0]                O_ALU_RESULT,
   output logic [4:0]                O_BSR,
   output logic                      O_ACC_VALID,
   output csf_pkg::csf_region_t      O_REGION,
   output logic [11:0]               O_PHYS_ADDR,
   output logic [7:0]                O_RDATA
);
   import csf_pkg::*;

   csf_status_t status_reg;
   logic [4:0]  bsr_reg;
   logic [7:0]  result_reg;
   logic        acc_valid_reg;
   csf_region_t region_reg;
   logic [11:0] phys_reg;
   logic [7:0]  rdata_reg;

   logic [7:0]  res_next;
   logic        z_next;
   logic        dc_next;
   logic        c_next;
   logic        set_z;
   logic        set_dc_c;
   logic [8:0]  sum9;
   logic [4:0]  sum5;
   logic [7:0]  addend;
   logic        cin;
   logic        direct_wr;
   logic        status_wr;
   logic        bsr_wr;
   logic [6:0]  dir_off;
   csf_region_t region_next;
   logic [11:0] phys_next;
   logic [11:0] lin_bank;
   logic [11:0] lin_off;

   // Bank offset to region; core area is shared by every bank
   function automatic csf_region_t csf_region(input logic [6:0] off);
      if (off < `CSF_PERIPH_FIRST) begin
         return CSF_RG_CORE;                          // see (RQ20)
      end else if (off < `CSF_GPR_FIRST) begin
         return CSF_RG_PERIPH;                        // see (RQ13)
      end else if (off < `CSF_COMMON_FIRST) begin
         return CSF_RG_GPR;                           // see (RQ14)
      end
      return CSF_RG_COMMON;
   endfunction : csf_region

   // Adder shared by add and subtract so both flags come from one carry chain
   always_comb begin
      addend = I_ALU.b;
      cin    = 1'b0;
      if (I_ALU.op == CSF_OP_SUB) begin
         addend = ~I_ALU.b;                           // see (RQ10)
         cin    = 1'b1;
      end
      sum9 = {1'b0, I_ALU.a} + {1'b0, addend} + {8'h00, cin};
      sum5 = {1'b0, I_ALU.a[3:0]} + {1'b0, addend[3:0]} + {4'h0, cin};
   end

   // Result and flag values per operation
   always_comb begin
      res_next = 8'h00;
      dc_next  = status_reg.dc;
      c_next   = status_reg.c;
      set_z    = 1'b1;
      set_dc_c = 1'b0;
      unique case (I_ALU.op)
         CSF_OP_ADD, CSF_OP_SUB: begin
            res_next = sum9[7:0];
            dc_next  = sum5[4];                       // see (RQ7) (RQ9)
            c_next   = sum9[8];                       // see (RQ8) (RQ9)
            set_dc_c = 1'b1;
         end
         CSF_OP_AND: res_next = I_ALU.a & I_ALU.b;
         CSF_OP_IOR: res_next = I_ALU.a | I_ALU.b;
         CSF_OP_XOR: res_next = I_ALU.a ^ I_ALU.b;
         CSF_OP_RL: begin
            res_next = {I_ALU.a[6:0], status_reg.c};
            c_next   = I_ALU.a[7];                    // see (RQ11)
            set_z    = 1'b0;
            set_dc_c = 1'b1;
         end
         CSF_OP_RR: begin
            res_next = {status_reg.c, I_ALU.a[7:1]};
            c_next   = I_ALU.a[0];                    // see (RQ11)
            set_z    = 1'b0;
            set_dc_c = 1'b1;
         end
         CSF_OP_PASS: res_next = I_ALU.a;
      endcase
      z_next = (res_next == 8'h00);                   // see (RQ6)
   end

   // Direct accesses to the core status and bank select registers
   assign dir_off   = I_ACC.addr[6:0];
   assign direct_wr = I_ACC.valid & I_ACC.write & ~I_ACC.linear & ~I_OTHER_RST;
   assign status_wr = direct_wr & (dir_off == `CSF_OFF_STATUS);
   assign bsr_wr    = direct_wr & (dir_off == `CSF_OFF_BSR);

   // Arithmetic flags: cleared only by power-on/brown-out, held on other resets
   always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
      if (!I_RST_N) begin
         status_reg.z  <= 1'b0;                       // see (RQ12)
         status_reg.dc <= 1'b0;
         status_reg.c  <= 1'b0;
      end else if (I_ALU.valid && !I_OTHER_RST) begin
         // Instruction flags override any same-cycle write to the status register
         if (set_z) begin
            status_reg.z <= z_next;                   // see (RQ18)
         end
         if (set_dc_c) begin
            status_reg.dc <= dc_next;
            status_reg.c  <= c_next;
         end
      end else if (status_wr) begin
         status_reg.z  <= I_ACC.wdata[`CSF_BIT_Z];
         status_reg.dc <= I_ACC.wdata[`CSF_BIT_DC];
         status_reg.c  <= I_ACC.wdata[`CSF_BIT_C];
      end
   end

   // Reset-cause flags: set at power-up, never software writable
   always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
      if (!I_RST_N) begin
         status_reg.to <= 1'b1;                       // see (RQ12)
      end else if (I_WDT_EXPIRE) begin
         // Expiry wins so a watchdog wake is never hidden by a same-cycle clear
         status_reg.to <= 1'b0;                       // see (RQ3)
      end else if (I_WDT_CLEAR || I_SLEEP) begin
         status_reg.to <= 1'b1;                       // see (RQ2)
      end
   end

   always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
      if (!I_RST_N) begin
         status_reg.pd <= 1'b1;                       // see (RQ12)
      end else if (I_SLEEP) begin
         status_reg.pd <= 1'b0;                       // see (RQ5)
      end else if (I_WDT_CLEAR) begin
         status_reg.pd <= 1'b1;                       // see (RQ4)
      end
   end

   // Unimplemented top bits are constant zero
   always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
      if (!I_RST_N) begin
         status_reg.unused <= 3'h0;
      end else begin
         status_reg.unused <= 3'h0;                   // see (RQ1)
      end
   end

   // Bank select register, cleared by every reset
   always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
      if (!I_RST_N) begin
         bsr_reg <= 5'h00;
      end else if (I_OTHER_RST) begin
         bsr_reg <= 5'h00;
      end else if (bsr_wr) begin
         bsr_reg <= I_ACC.wdata[4:0];                 // see (RQ17)
      end
   end

   // ALU result register
   always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
      if (!I_RST_N) begin
         result_reg <= 8'h00;
      end else if (I_ALU.valid) begin
         result_reg <= res_next;
      end
   end

   // Linear index split into bank and in-bank general RAM offset
   assign lin_bank = I_ACC.addr / `CSF_GPR_BYTES;
   assign lin_off  = (I_ACC.addr % `CSF_GPR_BYTES) + {5'h00, `CSF_GPR_FIRST};

   // Address decode; common bytes fold onto one bank so every bank sees them
   always_comb begin
      region_next = CSF_RG_NONE;
      phys_next   = 12'h000;
      if (I_ACC.linear) begin
         if (I_ACC.addr < `CSF_LINEAR_SIZE) begin
            region_next = CSF_RG_GPR;                 // see (RQ16)
            phys_next   = {lin_bank[4:0], lin_off[6:0]};
         end
      end else begin
         region_next = csf_region(dir_off);
         phys_next   = {bsr_reg, dir_off};            // see (RQ19)
         if (region_next == CSF_RG_COMMON) begin
            phys_next = {5'h00, dir_off};             // see (RQ15)
         end
      end
   end

   // Access answer registers; status and bank select read back here
   always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
      if (!I_RST_N) begin
         acc_valid_reg <= 1'b0;
         region_reg    <= CSF_RG_NONE;
         phys_reg      <= 12'h000;
         rdata_reg     <= 8'h00;
      end else begin
         acc_valid_reg <= I_ACC.valid & ~I_OTHER_RST;
         region_reg    <= region_next;
         phys_reg      <= phys_next;
         rdata_reg     <= 8'h00;
         if (I_ACC.valid && !I_ACC.linear && dir_off == `CSF_OFF_STATUS) begin
            rdata_reg <= status_reg;                  // see (RQ1)
         end else if (I_ACC.valid && !I_ACC.linear && dir_off == `CSF_OFF_BSR) begin
            rdata_reg <= {3'h0, bsr_reg};
         end
      end
   end

   assign O_STATUS     = status_reg;
   assign O_ALU_RESULT = result_reg;
   assign O_BSR        = bsr_reg;
   assign O_ACC_VALID  = acc_valid_reg;
   assign O_REGION     = region_reg;
   assign O_PHYS_ADDR  = phys_reg;
   assign O_RDATA      = rdata_reg;

   // Checks; the named steps below, all but s_rot_r, are shared by several properties
   sequence s_add;
      I_ALU.valid && !I_OTHER_RST && I_ALU.op == CSF_OP_ADD;
   endsequence
   sequence s_sub;
      I_ALU.valid && !I_OTHER_RST && I_ALU.op == CSF_OP_SUB;
   endsequence
   sequence s_rot_r;
      I_ALU.valid && !I_OTHER_RST && I_ALU.op == CSF_OP_RR;
   endsequence
   // Direct access through the selected bank, not the linear pointer
   sequence s_direct;
      I_ACC.valid && !I_ACC.linear;
   endsequence

   // Reset-cause, unimplemented status bit, arithmetic flag and address map checks
   unused_zero_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N) // see (RQ1)
      O_STATUS.unused == 3'h0 && (!O_ACC_VALID || O_RDATA[7:5] == 3'h0))
      else $error("status top bits not zero");
   to_set_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N) // see (RQ2)
      (I_SLEEP || I_WDT_CLEAR) && !I_WDT_EXPIRE |=> O_STATUS.to)
      else $error("timeout flag not set");
   to_clear_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N) // see (RQ3)
      I_WDT_EXPIRE |=> !O_STATUS.to ##1 (!O_STATUS.to || $past(I_SLEEP || I_WDT_CLEAR)))
      else $error("timeout flag not cleared");
   pd_flag_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N) // see (RQ4)
      I_WDT_CLEAR && !I_SLEEP |=> O_STATUS.pd)
      else $error("power-down flag not set");
   pd_sleep_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N) // see (RQ5)
      I_SLEEP |=> !O_STATUS.pd)
      else $error("power-down flag not cleared");
   zero_flag_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N) // see (RQ6)
      I_ALU.valid && !I_OTHER_RST && I_ALU.op != CSF_OP_RL && I_ALU.op != CSF_OP_RR
      |=> O_STATUS.z == (O_ALU_RESULT == 8'h00))
      else $error("zero flag wrong");
   add_carry_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N) // see (RQ8)
      s_add |=> O_STATUS.c == ({1'b0, $past(I_ALU.a)} + {1'b0, $past(I_ALU.b)} > 9'h0ff)
      && O_STATUS.dc == ({1'b0, $past(I_ALU.a[3:0])} + {1'b0, $past(I_ALU.b[3:0])} > 5'h0f))
      else $error("add carry flags wrong");
   sub_borrow_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N) // see (RQ9)
      s_sub |=> O_STATUS.c == ($past(I_ALU.a) >= $past(I_ALU.b))
      && O_ALU_RESULT == 8'($past(I_ALU.a) - $past(I_ALU.b)))
      else $error("subtract borrow wrong");
   rotate_c_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N) // see (RQ11)
      I_ALU.valid && !I_OTHER_RST && I_ALU.op == CSF_OP_RL |=> O_STATUS.c == $past(I_ALU.a[7])
      && O_ALU_RESULT[0] == $past(O_STATUS.c))
      else $error("rotate carry wrong");
   wr_suppress_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N) // see (RQ18)
      s_add and status_wr |=> O_STATUS.z == (O_ALU_RESULT == 8'h00))
      else $error("status write not suppressed");
   bank_map_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N) // see (RQ19)
      I_ACC.valid && !I_ACC.linear && dir_off < `CSF_COMMON_FIRST
      |=> O_PHYS_ADDR == {$past(bsr_reg), $past(dir_off)})
      else $error("bank address wrong");
   periph_map_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N) // see (RQ13)
      I_ACC.valid && !I_ACC.linear && dir_off inside {[7'h0c:7'h1f]}
      |=> O_REGION == CSF_RG_PERIPH)
      else $error("peripheral region wrong");
   common_map_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N) // see (RQ15)
      I_ACC.valid && !I_ACC.linear && dir_off >= `CSF_COMMON_FIRST
      |=> O_REGION == CSF_RG_COMMON && O_PHYS_ADDR[11:7] == 5'h00)
      else $error("common region wrong");

   // Arithmetic flag checks for rotate right, zero flag on both rotates and subtract nibble borrow
   rotate_right_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N) // see (RQ11)
      s_rot_r |=> O_STATUS.c == $past(I_ALU.a[0])
      && O_ALU_RESULT[7] == $past(O_STATUS.c))
      else $error("rotate right carry wrong");
   rotate_zero_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N) // see (RQ6)
      I_ALU.valid && !I_OTHER_RST && (I_ALU.op == CSF_OP_RL || I_ALU.op == CSF_OP_RR)
      |=> $stable(O_STATUS.z))
      else $error("rotate changed zero flag");
   sub_nibble_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N) // see (RQ9)
      s_sub |=> O_STATUS.dc == ($past(I_ALU.a[3:0]) >= $past(I_ALU.b[3:0])))
      else $error("subtract nibble borrow wrong");

   // Software access to the status and bank select registers, and other-reset handling
   flags_readonly_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N) // see (RQ12)
      status_wr && !I_WDT_CLEAR && !I_SLEEP && !I_WDT_EXPIRE
      |=> $stable(O_STATUS.to) && $stable(O_STATUS.pd))
      else $error("reset-cause flags written");
   status_write_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N) // see (RQ12)
      status_wr && !I_ALU.valid
      |=> {O_STATUS.z, O_STATUS.dc, O_STATUS.c} == $past(I_ACC.wdata[2:0]))
      else $error("status write lost");
   other_reset_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N) // see (RQ12)
      I_OTHER_RST |=> $stable({O_STATUS.z, O_STATUS.dc, O_STATUS.c}) && O_BSR == 5'h00)
      else $error("other reset handling wrong");
   status_read_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N) // see (RQ1)
      s_direct and dir_off == `CSF_OFF_STATUS
      |=> O_RDATA == {3'h0, $past(O_STATUS.to), $past(O_STATUS.pd), $past(O_STATUS.z),
      $past(O_STATUS.dc), $past(O_STATUS.c)})
      else $error("status read-back wrong");
   bsr_read_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N) // see (RQ17)
      s_direct and dir_off == `CSF_OFF_BSR |=> O_RDATA == {3'h0, $past(O_BSR)})
      else $error("bank select read-back wrong");
   bsr_write_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N) // see (RQ17)
      bsr_wr |=> O_BSR == $past(I_ACC.wdata[4:0]))
      else $error("bank select write lost");

   // Address map checks; one-hot regions so a wrong decode never aliases
   core_map_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N) // see (RQ20)
      s_direct and dir_off < `CSF_PERIPH_FIRST |=> O_REGION == CSF_RG_CORE)
      else $error("core region wrong");
   gpr_map_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N) // see (RQ14)
      s_direct and dir_off inside {[7'h20:7'h6f]}
      |=> O_REGION == CSF_RG_GPR)
      else $error("general RAM region wrong");
   linear_map_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N) // see (RQ16)
      I_ACC.valid && I_ACC.linear && I_ACC.addr < `CSF_LINEAR_SIZE
      |=> O_REGION == CSF_RG_GPR && O_PHYS_ADDR[6:0] >= `CSF_GPR_FIRST
      && O_PHYS_ADDR[6:0] < `CSF_COMMON_FIRST)
      else $error("linear map wrong");
   linear_none_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N) // see (RQ16)
      I_ACC.valid && I_ACC.linear && I_ACC.addr >= `CSF_LINEAR_SIZE
      |=> O_REGION == CSF_RG_NONE)
      else $error("linear range wrong");
endmodule : csf_core

/* tb.sv */
// Self-checking testbench for the status flags and bank decoder
`timescale 1ns/1ps
module tb;
   import csf_pkg::*;
   logic          clk;
   logic          rst_n;
   logic          other_rst;
   logic          wdt_clear;
   logic          sleep_i;
   logic          wdt_expire;
   csf_alu_req_t  alu;
   csf_acc_t      acc;
   csf_status_t   status;
   logic [7:0]    alu_result;
   logic [4:0]    bank_select_reg;
   logic          acc_valid;
   csf_region_t   region;
   logic [11:0]   phys;
   logic [7:0]    rdata;
   int            error_cnt   = 0;
   int            check_count = 0;

   csf_core i_csf_core (
      .I_CLK_SYS    (clk),
      .I_RST_N      (rst_n),
      .I_OTHER_RST  (other_rst),
      .I_WDT_CLEAR  (wdt_clear),
      .I_SLEEP      (sleep_i),
      .I_WDT_EXPIRE (wdt_expire),
      .I_ALU        (alu),
      .I_ACC        (acc),
      .O_STATUS     (status),
      .O_ALU_RESULT (alu_result),
      .O_BSR        (bank_select_reg),
      .O_ACC_VALID  (acc_valid),
      .O_REGION     (region),
      .O_PHYS_ADDR  (phys),
      .O_RDATA      (rdata)
   );

   // 250 MHz core clock
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   // Compare and count; values widened and compared with !== so an unknown bit never matches
   task automatic chk(input string what, input logic [11:0] exp, input logic [11:0] got);
      check_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   task automatic end_sim;
      $display("Checks %0d errors %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : end_sim

   task automatic do_reset;
      @(posedge clk);
      rst_n <= 1'b0;
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      #1;
      chk("status", 12'h018, 12'(status));
      chk("bsr", 12'h000, 12'(bank_select_reg));
   endtask : do_reset

   // Event pulse order is {watchdog clear, sleep, expire}
   task automatic ev(input logic [2:0] cse, input logic [7:0] exp);
      @(posedge clk);
      {wdt_clear, sleep_i, wdt_expire} <= cse;
      @(posedge clk);
      {wdt_clear, sleep_i, wdt_expire} <= 3'h0;
      #1;
      chk("status", {4'h0, exp}, {4'h0, status});
   endtask : ev

   // Flags given as {zero, nibble carry, carry}
   task automatic alu_op(input csf_alu_op_t op, input logic [7:0] a, input logic [7:0] b,
                         input logic [7:0] res, input logic [2:0] flg);
      @(posedge clk);
      alu <= '{1'b1, op, a, b};
      @(posedge clk);
      alu.valid <= 1'b0;
      #1;
      chk("alu result", {4'h0, res}, {4'h0, alu_result});
      chk("arith flags", {9'h0, flg}, {9'h0, status[2:0]});
   endtask : alu_op

   task automatic acc_op(input logic wr, input logic lin, input logic [11:0] addr,
                         input logic [7:0] wd, input csf_region_t rg, input logic [11:0] ph);
      @(posedge clk);
      acc <= '{1'b1, wr, lin, addr, wd};
      @(posedge clk);
      acc.valid <= 1'b0;
      #1;
      chk("acc valid", 12'h001, {11'h0, acc_valid});
      chk("region", {8'h0, rg}, {8'h0, region});
      if (rg != CSF_RG_NONE) begin
         chk("phys", ph, phys);
      end
   endtask : acc_op

   task automatic t_events;
      ev(3'h2, 8'h10);
      ev(3'h1, 8'h00);
      ev(3'h4, 8'h18);
      ev(3'h5, 8'h08);
      ev(3'h6, 8'h10);
   endtask : t_events

   // Rotates run through carry and leave zero and nibble carry alone
   task automatic t_alu;
      alu_op(CSF_OP_ADD, 8'h0f, 8'h01, 8'h10, 3'h2);
      alu_op(CSF_OP_ADD, 8'hff, 8'h01, 8'h00, 3'h7);
      alu_op(CSF_OP_SUB, 8'h05, 8'h05, 8'h00, 3'h7);
      alu_op(CSF_OP_SUB, 8'h10, 8'h01, 8'h0f, 3'h1);
      alu_op(CSF_OP_SUB, 8'h00, 8'h01, 8'hff, 3'h0);
      alu_op(CSF_OP_AND, 8'hf0, 8'h0f, 8'h00, 3'h4);
      alu_op(CSF_OP_IOR, 8'h0f, 8'h00, 8'h0f, 3'h0);
      alu_op(CSF_OP_XOR, 8'haa, 8'haa, 8'h00, 3'h4);
      alu_op(CSF_OP_PASS, 8'h00, 8'h00, 8'h00, 3'h4);
      alu_op(CSF_OP_RL, 8'h81, 8'h00, 8'h02, 3'h5);
      alu_op(CSF_OP_RR, 8'h02, 8'h00, 8'h81, 3'h4);
   endtask : t_alu

   task automatic t_status_write;
      acc_op(1'b1, 1'b0, 12'h003, 8'hff, CSF_RG_CORE, 12'h003);
      chk("status", 12'h017, 12'(status));
      // Same-cycle ALU op must win over the software write
      @(posedge clk);
      acc <= '{1'b1, 1'b1, 1'b0, 12'h003, 8'h07};
      alu <= '{1'b1, CSF_OP_ADD, 8'h01, 8'h01};
      @(posedge clk);
      acc.valid <= 1'b0;
      alu.valid <= 1'b0;
      #1;
      chk("status", 12'h010, 12'(status));
      acc_op(1'b0, 1'b0, 12'h003, 8'h00, CSF_RG_CORE, 12'h003);
      chk("rdata", 12'h010, {4'h0, rdata});
   endtask : t_status_write

   task automatic t_other;
      alu_op(CSF_OP_ADD, 8'hff, 8'h01, 8'h00, 3'h7);
      acc_op(1'b1, 1'b0, 12'h008, 8'h05, CSF_RG_CORE, 12'h008);
      chk("bsr", 12'h005, 12'(bank_select_reg));
      // An ALU request during the reset pulse leaves the flags alone but still loads the result register
      @(posedge clk);
      other_rst <= 1'b1;
      alu <= '{1'b1, CSF_OP_ADD, 8'h00, 8'h00};
      @(posedge clk);
      other_rst <= 1'b0;
      alu.valid <= 1'b0;
      #1;
      chk("status", 12'h017, 12'(status));
      chk("bsr", 12'h000, 12'(bank_select_reg));
   endtask : t_other

   task automatic t_map;
      acc_op(1'b1, 1'b0, 12'h008, 8'h1f, CSF_RG_CORE, 12'h008);
      chk("bsr", 12'h01f, 12'(bank_select_reg));
      acc_op(1'b0, 1'b0, 12'h008, 8'h00, CSF_RG_CORE, 12'hf88);
      chk("rdata", 12'h01f, {4'h0, rdata});
      @(posedge clk);
      #1;
      chk("acc valid", 12'h000, {11'h0, acc_valid});
      acc_op(1'b0, 1'b0, 12'h00b, 8'h00, CSF_RG_CORE, 12'hf8b);
      acc_op(1'b0, 1'b0, 12'h00c, 8'h00, CSF_RG_PERIPH, 12'hf8c);
      acc_op(1'b0, 1'b0, 12'h01f, 8'h00, CSF_RG_PERIPH, 12'hf9f);
      acc_op(1'b0, 1'b0, 12'h020, 8'h00, CSF_RG_GPR, 12'hfa0);
      acc_op(1'b0, 1'b0, 12'h06f, 8'h00, CSF_RG_GPR, 12'hfef);
      acc_op(1'b0, 1'b0, 12'h070, 8'h00, CSF_RG_COMMON, 12'h070);
      acc_op(1'b0, 1'b0, 12'h07f, 8'h00, CSF_RG_COMMON, 12'h07f);
      acc_op(1'b0, 1'b1, 12'h000, 8'h00, CSF_RG_GPR, 12'h020);
      acc_op(1'b0, 1'b1, 12'h050, 8'h00, CSF_RG_GPR, 12'h0a0);
      acc_op(1'b0, 1'b1, 12'h9ff, 8'h00, CSF_RG_GPR, 12'hfef);
      acc_op(1'b0, 1'b1, 12'ha00, 8'h00, CSF_RG_NONE, 12'h000);
   endtask : t_map

   // Cuts a hang short after far more cycles than the run needs
   initial begin
      repeat (3000) @(posedge clk);
      error_cnt++;
      end_sim();
   end

   // Main sequence, ending with a second power-on reset before the summary
   initial begin
      rst_n      = 1'b0;
      other_rst  = 1'b0;
      wdt_clear  = 1'b0;
      sleep_i    = 1'b0;
      wdt_expire = 1'b0;
      alu        = '0;
      acc        = '0;
      do_reset();
      t_events();
      t_alu();
      t_status_write();
      t_other();
      t_map();
      do_reset();
      end_sim();
   end
endmodule : tb
